// *** gauge_power_mode_control.sv ***
// Power-mode, conversion sequencing and APB registers of the gauge.
// Assumes bus line, pins and ADC sample come from outside pclk domain.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module gauge_power_mode_control
   import gauge_pkg::*;
#(
   parameter int unsigned SLEEP_CYC = SLEEP_TIMEOUT_CYC,
   parameter int unsigned CONV_CYC = CONV_PERIOD_CYC,
   parameter int unsigned LEAD_CYC = LEAD_TIME_CYC,
   parameter int unsigned ACQ_CYC = CONV_TIME_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic bus_line_in,
   input wire logic speed_select_pin,
   input wire logic user_io_pin_in,
   output logic user_io_pin_out,
   output logic user_io_pin_oe,
   output logic divider_enable_out,
   // Converter sample, signed, 4.88 mV per step
   input wire logic signed [17:0] cell_voltage_input,
   // Status to the rest of the gauge
   output logic measure_enable,
   output logic display_enable,
   output logic presence_suppress,
   output logic normal_speed,
   output logic [15:0] bit_time_cyc
);
   if (SLEEP_CYC < 2 || LEAD_CYC < 1 || ACQ_CYC < 1 ||
      CONV_CYC <= LEAD_CYC + ACQ_CYC) begin : g_bad_timing
      $error("gauge_power_mode_control: bad timing parameters");
   end
   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic line_s;
   logic speed_s;
   logic pio_s;
   sync2 u_line (.pclk(pclk), .presetn(presetn), .d(bus_line_in), .q(line_s));
   sync2 u_spd (.pclk(pclk), .presetn(presetn), .d(speed_select_pin),
      .q(speed_s));
   sync2 u_pio (.pclk(pclk), .presetn(presetn), .d(user_io_pin_in),
      .q(pio_s));
   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [3:0] ctrl_q, ctrl_d;
   logic [31:0] user_q [USER_WORDS];
   logic [31:0] user_d [USER_WORDS];
   logic [31:0] rdata_d;
   logic wr_en;
   logic hit;
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   logic [15:0] cell_voltage_reg_q, cell_voltage_reg_d;
   power_mode_t mode_q, mode_d;
   logic disp_q, disp_d;
   always_comb begin
      ctrl_d = ctrl_q;
      for (int i = 0; i < USER_WORDS; i++)
         user_d[i] = user_q[i];
      rdata_d = 32'h0;
      hit = 1'b1;
      case (paddr)
         ADDR_CTRL: rdata_d = {28'h0, ctrl_q};
         ADDR_STATUS: rdata_d = {26'h0, disp_q, presence_suppress,
            normal_speed, line_s, mode_q};
         ADDR_CELL_VOLTAGE_REG: rdata_d = {16'h0, cell_voltage_reg_q};
         ADDR_ID_LO: rdata_d = {SERIAL_NUM[23:0], FAMILY_CODE};
         ADDR_ID_HI: rdata_d = {CHECK_CODE, SERIAL_NUM[47:24]};
         default: begin
            hit = 1'b0;
            if (paddr[11:4] == ADDR_USER[11:4] && paddr[1:0] == 2'b00) begin
               hit = 1'b1;
               rdata_d = user_q[paddr[3:2]];
            end
         end
      endcase
      if (wr_en && hit) begin
         if (paddr == ADDR_CTRL)
            ctrl_d = pwdata[3:0];
         else if (paddr[11:4] == ADDR_USER[11:4])
            user_d[paddr[3:2]] = pwdata;
      end
   end
   assign pslverr = psel && penable && !hit;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
         prdata <= 32'h0;
         for (int i = 0; i < USER_WORDS; i++)
            user_q[i] <= 32'h0;
      end else begin
         ctrl_q <= ctrl_d;
         if (psel && !penable)
            prdata <= rdata_d;
         for (int i = 0; i < USER_WORDS; i++)
            user_q[i] <= user_d[i];
      end
   end
   // ****************************************************************
   // Speed select
   // ****************************************************************
   // pin high means overdrive
   assign normal_speed = !speed_s;
   assign bit_time_cyc = speed_s ? OVERDRIVE_BIT_CYC : NORMAL_BIT_CYC;
   // ****************************************************************
   // Power mode
   // ****************************************************************
   logic [31:0] idle_cnt_q, idle_cnt_d;
   logic line_prev_q;
   logic uv_line_q, uv_line_d;
   logic suppress_q, suppress_d;
   logic line_edge;
   logic line_rise;
   logic timed_out;
   logic under_v;
   assign line_edge = line_s != line_prev_q;
   assign line_rise = line_s && !line_prev_q;
   assign timed_out = idle_cnt_q >= SLEEP_CYC - 1;
   assign under_v = $signed(cell_voltage_reg_q) < $signed(UV_THRESHOLD_CODE);
   always_comb begin
      mode_d = mode_q;
      uv_line_d = uv_line_q;
      suppress_d = suppress_q;
      if (line_edge || mode_q != MODE_ACTIVE)
         idle_cnt_d = 32'h0;
      else if (!timed_out)
         idle_cnt_d = idle_cnt_q + 32'h1;
      else
         idle_cnt_d = idle_cnt_q;
      if (line_rise)
         suppress_d = 1'b0;
      case (mode_q)
         MODE_ACTIVE: begin
            if (timed_out && !line_edge) begin
               if (ctrl_q[CTRL_IDLE_EN] && !line_s) begin
                  mode_d = MODE_IDLE_SLEEP;
                  suppress_d = 1'b1;
               end else if (ctrl_q[CTRL_UV_EN] && under_v) begin
                  mode_d = MODE_UV_SLEEP;
                  uv_line_d = line_s;
                  // line high needs no extra edge
                  suppress_d = !line_s;
               end
            end
         end
         MODE_IDLE_SLEEP: if (line_s) mode_d = MODE_ACTIVE;
         MODE_UV_SLEEP: if (line_edge) mode_d = MODE_ACTIVE;
         default: mode_d = MODE_ACTIVE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_ACTIVE;
         idle_cnt_q <= 32'h0;
         line_prev_q <= 1'b0;
         uv_line_q <= 1'b0;
         suppress_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         idle_cnt_q <= idle_cnt_d;
         line_prev_q <= line_s;
         uv_line_q <= uv_line_d;
         suppress_q <= suppress_d;
      end
   end
   assign measure_enable = mode_q == MODE_ACTIVE;
   assign presence_suppress = suppress_q;
   // ****************************************************************
   // Conversion sequencer
   // ****************************************************************
   conv_state_t cv_q, cv_d;
   logic [31:0] cv_cnt_q, cv_cnt_d;
   logic signed [15:0] sat_code;
   // Sample crosses in from the converter; two flops keep metastability
   // off the clamp, and the converter holds it still over a conversion
   logic signed [17:0] samp1_q, samp1_d;
   logic signed [17:0] samp2_q, samp2_d;
   always_comb begin
      samp1_d = cell_voltage_input;
      samp2_d = samp1_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp1_q <= 18'sh0;
         samp2_q <= 18'sh0;
      end else begin
         samp1_q <= samp1_d;
         samp2_q <= samp2_d;
      end
   end
   cell_voltage_reg_sat u_sat (.raw(samp2_q), .code(sat_code));
   always_comb begin
      cv_d = cv_q;
      cv_cnt_d = cv_cnt_q + 32'h1;
      cell_voltage_reg_d = cell_voltage_reg_q;
      case (cv_q)
         CV_WAIT: begin
            // idle gap before the lead time counted on the time base
            if (cv_cnt_q >= CONV_CYC - LEAD_CYC - ACQ_CYC - 1) begin
               cv_d = CV_LEAD;
               cv_cnt_d = 32'h0;
            end
         end
         CV_LEAD: if (cv_cnt_q >= LEAD_CYC - 1) begin
            cv_d = CV_CONV;
            cv_cnt_d = 32'h0;
         end
         CV_CONV: if (cv_cnt_q >= ACQ_CYC - 1) begin
            cv_d = CV_WAIT;
            cv_cnt_d = 32'h0;
            cell_voltage_reg_d = sat_code;
         end
         default: begin
            cv_d = CV_WAIT;
            cv_cnt_d = 32'h0;
         end
      endcase
      // Sleep holds the sequence in CV_WAIT at count zero and keeps the last result
      if (!measure_enable) begin
         cv_d = CV_WAIT;
         cv_cnt_d = 32'h0;
         cell_voltage_reg_d = cell_voltage_reg_q;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cv_q <= CV_WAIT;
         cv_cnt_q <= 32'h0;
         cell_voltage_reg_q <= 16'h0;
         divider_enable_out <= 1'b0;
      end else begin
         cv_q <= cv_d;
         cv_cnt_q <= cv_cnt_d;
         cell_voltage_reg_q <= cell_voltage_reg_d;
         divider_enable_out <= cv_d != CV_WAIT;
      end
   end
   // ****************************************************************
   // User pin and display
   // ****************************************************************
   logic pio_prev_q;
   always_comb begin
      disp_d = disp_q;
      if (!ctrl_q[CTRL_PIO_DRIVE] && pio_s && !pio_prev_q)
         disp_d = 1'b1;
      else if (wr_en && paddr == ADDR_STATUS && pwdata[5])
         disp_d = 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_q <= 1'b0;
         pio_prev_q <= 1'b0;
      end else begin
         disp_q <= disp_d;
         pio_prev_q <= pio_s;
      end
   end
   assign display_enable = disp_q;
   // Open drain: only ever pulls low
   assign user_io_pin_out = 1'b0;
   assign user_io_pin_oe = ctrl_q[CTRL_PIO_DRIVE] && !ctrl_q[CTRL_PIO_OUT];
   // ****************************************************************
   // Checks
   // ****************************************************************
   a_sleep_no_measure: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q != MODE_ACTIVE |-> !measure_enable
      ##1 (!divider_enable_out && cv_q == CV_WAIT))
      else $error("measuring while asleep");
   a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == MODE_IDLE_SLEEP && line_s |=> mode_q == MODE_ACTIVE)
      else $error("idle sleep did not wake");
   a_idle_entry: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(mode_q == MODE_IDLE_SLEEP) |-> $past(ctrl_q[CTRL_IDLE_EN])
      && !$past(line_s) && $past(idle_cnt_q) >= SLEEP_CYC - 1)
      else $error("idle sleep entered without cause");
   a_uv_hold: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == MODE_UV_SLEEP && !line_edge |=> mode_q == MODE_UV_SLEEP)
      else $error("undervoltage sleep left early");
   a_divider_lead: assert property (@(posedge pclk) disable iff (!presetn)
      cv_q == CV_CONV |-> divider_enable_out)
      else $error("divider off during conversion");
   a_cell_voltage_reg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q != MODE_ACTIVE |=> $stable(cell_voltage_reg_q))
      else $error("voltage changed in sleep");
   a_speed_pick: assert property (@(posedge pclk) disable iff (!presetn)
      normal_speed == !speed_s && bit_time_cyc ==
      (speed_s ? OVERDRIVE_BIT_CYC : NORMAL_BIT_CYC))
      else $error("wrong bit time");
   a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
      line_edge |=> idle_cnt_q == 32'h0)
      else $error("sleep timer not restarted");
endmodule // gauge_power_mode_control

// *** gauge_pkg.sv ***
// Constants shared by the gauge power-mode control design.
// Assumes a single 25 MHz pclk and an APB master for register access.
package gauge_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned SLEEP_TIMEOUT_MS = 2000;
   localparam int unsigned SLEEP_TIMEOUT_CYC =
      SLEEP_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned CONV_PERIOD_MS = 440;
   localparam int unsigned CONV_PERIOD_CYC = CONV_PERIOD_MS * (CLK_HZ / 1000);
   localparam int unsigned LEAD_TIME_US = 1000;
   localparam int unsigned LEAD_TIME_CYC = LEAD_TIME_US * (CLK_HZ / 1000000);
   localparam int unsigned CONV_TIME_US = 2000;
   localparam int unsigned CONV_TIME_CYC = CONV_TIME_US * (CLK_HZ / 1000000);
   localparam int unsigned NORMAL_BPS = 16000;
   localparam int unsigned OVERDRIVE_BPS = 140000;
   localparam logic [15:0] NORMAL_BIT_CYC =
      16'((CLK_HZ + NORMAL_BPS - 1) / NORMAL_BPS);
   localparam logic [15:0] OVERDRIVE_BIT_CYC =
      16'((CLK_HZ + OVERDRIVE_BPS - 1) / OVERDRIVE_BPS);
   // ****************************************************************
   // Voltage format: 4.88 mV per LSB, 16-bit signed
   // ****************************************************************
   localparam int unsigned CELL_VOLTAGE_REG_LSB_UV = 4880;
   localparam logic signed [15:0] CELL_VOLTAGE_REG_MAX = 16'sh7fff;
   localparam logic signed [15:0] CELL_VOLTAGE_REG_MIN = 16'sh8000;
   localparam logic [15:0] UV_THRESHOLD_CODE = 16'h01f6;
   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CELL_VOLTAGE_REG = 12'h008;
   localparam logic [11:0] ADDR_ID_LO = 12'h00c;
   localparam logic [11:0] ADDR_ID_HI = 12'h010;
   localparam logic [11:0] ADDR_USER = 12'h040;
   localparam int unsigned USER_WORDS = 4;
   localparam int unsigned CTRL_IDLE_EN = 0;
   localparam int unsigned CTRL_UV_EN = 1;
   localparam int unsigned CTRL_PIO_OUT = 2;
   localparam int unsigned CTRL_PIO_DRIVE = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // Arbitrary neutral identity values
   localparam logic [7:0] FAMILY_CODE = 8'h5a;
   localparam logic [47:0] SERIAL_NUM = 48'h0123456789ab;
   localparam logic [7:0] CHECK_CODE = 8'hc3;
   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'b00,
      MODE_IDLE_SLEEP = 2'b01,
      MODE_UV_SLEEP = 2'b10
   } power_mode_t;
   typedef enum logic [1:0] {
      CV_WAIT = 2'b00,
      CV_LEAD = 2'b01,
      CV_CONV = 2'b10
   } conv_state_t;
endpackage

// *** sync2.sv ***
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is quasi-static relative to pclk.
`timescale 1ns/1ps
module sync2 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s1_d;
   logic s2_d;
   always_comb begin
      s1_d = d;
      s2_d = s1_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end
   assign q = s2_q;
endmodule // sync2

// *** cell_voltage_reg_sat.sv ***
// Saturating converter from raw signed sample to the voltage code.
// Assumes the raw sample is already scaled to 4.88 mV steps.
`timescale 1ns/1ps
module cell_voltage_reg_sat import gauge_pkg::*; (
   // Raw sample
   input wire logic signed [17:0] raw,
   // Saturated code
   output logic signed [15:0] code
);
   always_comb begin
      if (raw > 18'(CELL_VOLTAGE_REG_MAX))
         code = CELL_VOLTAGE_REG_MAX;
      else if (raw < 18'(CELL_VOLTAGE_REG_MIN))
         code = CELL_VOLTAGE_REG_MIN;
      else
         code = raw[15:0];
   end
endmodule // cell_voltage_reg_sat

// *** bus_master_model.sv ***
// Model of the single-wire bus master standing on the gauge data line.
// Assumes a weak pull-down holds the line low whenever it is released.
`timescale 1ns/1ps
module bus_master_model (
   // Clock
   input wire logic pclk,
   // Line
   output logic bus_line
);
   // ****************************************************************
   // Line drive
   // ****************************************************************
   initial bus_line = 1'b0;
   // Level 0 stands for a released line held low by the weak pull-down
   task automatic hold(input logic lvl, input int n);
      bus_line <= lvl;
      repeat (n) @(posedge pclk);
   endtask
   task automatic reset_pulse(input int n);
      hold(1'b1, 8);
      hold(1'b0, n);
      hold(1'b1, 8);
   endtask
endmodule // bus_master_model

// *** gauge_power_mode_control_test.sv ***
// Self-checking bench for the gauge power-mode control block.
// Assumes the bus master model file and shortened timing parameters.
`timescale 1ns/1ps
module gauge_power_mode_control_test;
   import gauge_pkg::*;
   localparam int SC = 50;
   localparam int CC = 100;
   localparam int LC = 5;
   localparam int AC = 10;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic bus_line_in;
   logic speed_select_pin = 1'b0;
   logic pio_drv = 1'b0;
   wire logic user_io_pin_in;
   logic user_io_pin_out;
   logic user_io_pin_oe;
   logic divider_enable_out;
   logic signed [17:0] cell_voltage_input = 18'sh0;
   logic measure_enable;
   logic display_enable;
   logic presence_suppress;
   logic normal_speed;
   logic [15:0] bit_time_cyc;
   logic [31:0] rng = 32'hd61baa07;
   logic [31:0] rd;
   logic err;
   logic [31:0] mem_m [4];
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   int vals [$];
   int n;
   // Open-drain pin: the gauge pulling low wins over the bench
   assign user_io_pin_in = user_io_pin_oe ? 1'b0 : pio_drv;
   always #20 pclk = ~pclk;
   gauge_power_mode_control #(.SLEEP_CYC(SC), .CONV_CYC(CC),
      .LEAD_CYC(LC), .ACQ_CYC(AC)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_line_in(bus_line_in),
      .speed_select_pin(speed_select_pin),
      .user_io_pin_in(user_io_pin_in), .user_io_pin_out(user_io_pin_out),
      .user_io_pin_oe(user_io_pin_oe),
      .divider_enable_out(divider_enable_out),
      .cell_voltage_input(cell_voltage_input),
      .measure_enable(measure_enable), .display_enable(display_enable),
      .presence_suppress(presence_suppress), .normal_speed(normal_speed),
      .bit_time_cyc(bit_time_cyc));
   bus_master_model bus (.pclk(pclk), .bus_line(bus_line_in));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Caller stands just after a rising edge; one idle cycle follows
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk_mode(input int m);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("mode", 32'(rd[1:0]), 32'(m));
      check("measure", 32'(measure_enable), 32'(m == 0));
   endtask
   task automatic chk_mem();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ADDR_USER + 12'(4 * i), 32'h0);
         check("user_mem", rd, mem_m[i]);
      end
   endtask
   task automatic chk_cell_voltage_reg(input int v);
      int e;
      e = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
      apb(1'b0, ADDR_CELL_VOLTAGE_REG, 32'h0);
      check("cell_voltage_reg", 32'(rd[15:0]), 32'(e) & 32'hffff);
   endtask
   // Sample held still from one idle gap to the next, across the whole conversion
   task automatic conv_check(input int v);
      int h;
      int l;
      int k;
      h = 0;
      l = 0;
      k = 0;
      while (divider_enable_out !== 1'b0 && k < 4 * CC) begin
         @(posedge pclk);
         k++;
      end
      cell_voltage_input <= 18'(v);
      while (divider_enable_out !== 1'b1 && k < 4 * CC) begin
         @(posedge pclk);
         k++;
      end
      while (divider_enable_out === 1'b1 && h < 4 * CC) begin
         @(posedge pclk);
         h++;
      end
      while (divider_enable_out !== 1'b1 && l < 4 * CC) begin
         @(posedge pclk);
         l++;
      end
      check("lead_conv", 32'(h), 32'(LC + AC));
      check("period", 32'(h + l), 32'(CC));
      chk_cell_voltage_reg(v);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("measure_rst", 32'(measure_enable), 32'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl_rst", rd, 32'h0);
      // Line low with both options off must not sleep
      repeat (SC + 10) @(posedge pclk);
      chk_mode(0);
      for (int s = 0; s < 2; s++) begin
         speed_select_pin <= s[0];
         repeat (4) @(posedge pclk);
         check("normal_speed", 32'(normal_speed), 32'(s == 0));
         check("bit_time", 32'(bit_time_cyc), s == 1 ?
            (CLK_HZ + 139999) / 140000 : (CLK_HZ + 15999) / 16000);
      end
      apb(1'b0, ADDR_ID_LO, 32'h0);
      check("id_lo", rd, {SERIAL_NUM[23:0], FAMILY_CODE});
      apb(1'b0, ADDR_ID_HI, 32'h0);
      check("id_hi", rd, {CHECK_CODE, SERIAL_NUM[47:24]});
      for (int i = 0; i < 4; i++) begin
         mem_m[i] = xs();
         apb(1'b1, ADDR_USER + 12'(4 * i), mem_m[i]);
      end
      apb(1'b1, 12'h100, 32'h5);
      check("err_wr", 32'(err), 32'h1);
      apb(1'b0, 12'h100, 32'h0);
      check("err_rd", {31'h0, err} ^ rd, 32'h1);
      chk_mem();
      bus.hold(1'b1, 4);
      vals = '{131071, -131072, 32767, -32768};
      for (int i = 0; i < 2; i++) begin
         rd = xs();
         vals.push_back(int'($signed(rd[17:0])));
      end
      // Last sample stays under the undervoltage code
      vals.push_back(100);
      foreach (vals[i]) conv_check(vals[i]);
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (SC + 10) @(posedge pclk);
      chk_mode(2);
      check("presence_hi", 32'(presence_suppress), 32'h0);
      bus.hold(1'b0, 6);
      chk_mode(0);
      repeat (SC + 10) @(posedge pclk);
      chk_mode(2);
      check("presence_lo", 32'(presence_suppress), 32'h1);
      bus.reset_pulse(20);
      chk_mode(0);
      check("presence_clr", 32'(presence_suppress), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      bus.hold(1'b0, 40);
      bus.hold(1'b1, 3);
      bus.hold(1'b0, SC - 10);
      chk_mode(0);
      repeat (20) @(posedge pclk);
      chk_mode(1);
      check("presence_idle", 32'(presence_suppress), 32'h1);
      cell_voltage_input <= 18'sd3000;
      n = 0;
      repeat (2 * CC) begin
         @(posedge pclk);
         if (divider_enable_out !== 1'b0) n++;
      end
      check("div_sleep", 32'(n), 32'h0);
      chk_cell_voltage_reg(100);
      chk_mem();
      bus.hold(1'b1, 6);
      chk_mode(0);
      check("presence_wake", 32'(presence_suppress), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h0);
      pio_drv <= 1'b1;
      repeat (6) @(posedge pclk);
      check("display_on", 32'(display_enable), 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h20);
      check("display_clr", 32'(display_enable), 32'h0);
      pio_drv <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'hc);
      check("oe_rel", 32'(user_io_pin_oe), 32'h0);
      pio_drv <= 1'b1;
      repeat (6) @(posedge pclk);
      check("display_out", 32'(display_enable), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h8);
      check("oe_low", 32'({user_io_pin_oe, user_io_pin_out}), 32'h2);
      final_report();
   end
endmodule // gauge_power_mode_control_test
